// *** inc/adc_seq_pkg.sv ***
// constants and types of the adc channel sequencer
// How it works
// - mux advances when a conversion phase ends
// - standard mode converts each enabled channel once
// - standard sequence holds one to nine entries
// - standard mode uses first channel oversampling ratio
// - advanced mode uses slot count plus one slots
// - advanced length capped at implemented slot registers
// - command mode has no device length limit
// - sensor cannot be placed in a slot
// - sensor include bit adds one sensor conversion
// - standard sequencer selected after reset
// - standard mode and sensor share first config; others own
package adc_seq_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_MASK   = 8'h04;
    localparam logic [7:0] OFS_TEMP   = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    // channel configs at 0x20..0x3c, slots at 0x40..0x7c
    localparam logic [2:0] CFG_HI     = 3'h1;
    localparam logic [1:0] SLOT_HI    = 2'h1;
    localparam logic [1:0] ALIGN      = 2'h0;

    // field layout
    localparam int CTRL_SEL_BIT   = 7;
    localparam int CNT_W          = 4;
    localparam int N_INPUTS       = 8;
    localparam int IN_W           = 3;
    localparam int CH_W           = 4;
    localparam int OSR_W          = 2;
    localparam int OSR_CNT_W      = 6;
    localparam int STAT_POS_LSB   = 4;
    localparam int STAT_MODE_LSB  = 8;
    localparam int STAT_PHASE_BIT = 11;
    localparam int MODE_W         = 3;

    // reset values
    localparam logic             CTRL_SEL_RST = 1'b1;
    localparam logic [CNT_W-1:0] CNT_RST      = 4'h0;
    localparam logic [7:0]       MASK_RST     = 8'h01;
    localparam logic             TEMP_RST     = 1'b0;
    localparam logic [OSR_W-1:0] OSR_RST      = 2'h0;
    localparam logic [IN_W-1:0]  SLOT_RST     = 3'h0;

    // channel codes: inputs 0..7, sensor 8
    localparam logic [CH_W-1:0]  CH_TEMP      = 4'h8;
    localparam logic [OSR_W-1:0] OSR_ONE      = 2'h0;

    typedef enum logic [MODE_W-1:0] {
        MODE_STD = 3'b001,
        MODE_ADV = 3'b010,
        MODE_CMD = 3'b100
    } seq_mode_t;

endpackage

// *** logic/adc_channel_sequencer.sv ***
// channel sequencer with avalon-mm register slave
module adc_channel_sequencer #(
    parameter int NUM_SLOTS = 16
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // converter core
    input  wire logic        conversion_done,
    output logic      [3:0]  mux_select,
    output logic      [2:0]  config_select,
    output logic             result_done,
    output logic             seq_wrap,
    // host per-frame channel choice
    input  wire logic [3:0]  next_channel,
    input  wire logic        next_channel_valid
);

    localparam logic [3:0] SLOT_MAX = 4'(NUM_SLOTS - 1);

    // next enabled entry after cur, wrapping over nine entries
    function automatic logic [3:0] std_next(
        input logic [8:0] m,
        input logic [3:0] cur
    );
        logic [3:0] r;
        logic       f;
        int         k;
        r = cur;
        f = 1'b0;
        for (int i = 1; i <= 9; i++) begin
            k = (int'(cur) + i) % 9;
            if (!f && m[k]) begin
                r = 4'(k);
                f = 1'b1;
            end
        end
        return r;
    endfunction

    // bus state
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // software registers
    logic                            sel_std_reg;
    logic [adc_seq_pkg::CNT_W-1:0]   slot_cnt_reg;
    logic [7:0]                      mask_reg;
    logic                            temp_en_reg;
    logic [adc_seq_pkg::OSR_W-1:0]   cfg_reg  [adc_seq_pkg::N_INPUTS];
    logic [adc_seq_pkg::IN_W-1:0]    slot_reg [NUM_SLOTS];

    // sequencer state
    logic [3:0]                        pos_reg;
    logic [3:0]                        pos_next;
    logic                              phase_reg;
    logic                              phase_next;
    logic                              wrap_next;
    logic [3:0]                        mux_reg;
    logic [3:0]                        mux_next;
    logic [2:0]                        cfg_sel_reg;
    logic [adc_seq_pkg::OSR_CNT_W-1:0] osr_cnt_reg;
    logic                              result_reg;
    logic                              wrap_reg;
    logic                              restart_reg;
    logic [3:0]                        cmd_chan_reg;
    logic                              cmd_pend_reg;

    // decode
    wire       req       = avs_read | avs_write;
    wire       accept    = req & wait_reg;
    wire       aligned   = avs_address[1:0] == adc_seq_pkg::ALIGN;
    wire       sel_ctrl  = avs_address == adc_seq_pkg::OFS_CTRL;
    wire       sel_mask  = avs_address == adc_seq_pkg::OFS_MASK;
    wire       sel_temp  = avs_address == adc_seq_pkg::OFS_TEMP;
    wire       sel_stat  = avs_address == adc_seq_pkg::OFS_STATUS;
    wire [2:0] cfg_idx   = avs_address[4:2];
    wire [3:0] slot_idx  = avs_address[5:2];
    wire       sel_cfg   = aligned & (avs_address[7:5] == adc_seq_pkg::CFG_HI);
    wire       sel_slot  = aligned & (avs_address[7:6] == adc_seq_pkg::SLOT_HI)
                           & (slot_idx <= SLOT_MAX);
    // a write lands on the edge where waitrequest is seen low
    wire       wr_go     = avs_write & ~wait_reg & avs_byteenable[0];
    // changing mode or channel set starts the pass over
    wire       restart   = wr_go & (sel_ctrl | sel_mask | sel_temp);

    // mode decode; command mode needs a zero slot count
    adc_seq_pkg::seq_mode_t mode;
    assign mode = sel_std_reg ? adc_seq_pkg::MODE_STD :
                  (slot_cnt_reg != adc_seq_pkg::CNT_RST) ?
                  adc_seq_pkg::MODE_ADV : adc_seq_pkg::MODE_CMD;

    wire is_std = mode == adc_seq_pkg::MODE_STD;
    wire is_adv = mode == adc_seq_pkg::MODE_ADV;
    wire is_cmd = mode == adc_seq_pkg::MODE_CMD;

    // sensor is the ninth entry of the standard set
    wire [8:0] mask9 = {temp_en_reg, mask_reg};
    wire [3:0] std_nxt   = std_next(mask9, pos_reg);
    wire [3:0] std_first = std_next(mask9, adc_seq_pkg::CH_TEMP);

    // counts above the implemented slots are clamped
    wire [3:0] slot_eff = (slot_cnt_reg > SLOT_MAX) ? SLOT_MAX
                                                     : slot_cnt_reg;
    wire       adv_last = pos_reg == slot_eff;

    // oversampling: shared field in standard mode, own otherwise, sensor fixed at one
    wire [adc_seq_pkg::OSR_W-1:0] osr_sel =
        is_std ? cfg_reg[0] :
        (mux_reg == adc_seq_pkg::CH_TEMP) ? adc_seq_pkg::OSR_ONE :
        cfg_reg[mux_reg[2:0]];
    wire [6:0] ratio_hot = 7'h01 << {osr_sel, 1'b0};
    wire [adc_seq_pkg::OSR_CNT_W-1:0] ratio_m1 =
        adc_seq_pkg::OSR_CNT_W'(ratio_hot - 7'h01);
    wire step = conversion_done & (osr_cnt_reg == ratio_m1);

    // bus handshake: one wait cycle per request
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0;
        end else begin
            wait_reg  <= ~accept;
            if (accept && avs_read) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = 32'h0;
        if (sel_ctrl) begin
            rdata_next[adc_seq_pkg::CTRL_SEL_BIT] = sel_std_reg;
            rdata_next[adc_seq_pkg::CNT_W-1:0]    = slot_cnt_reg;
        end else if (sel_mask) begin
            rdata_next[7:0] = mask_reg;
        end else if (sel_temp) begin
            rdata_next[0] = temp_en_reg;
        end else if (sel_stat) begin
            rdata_next[adc_seq_pkg::CH_W-1:0] = mux_reg;
            rdata_next[adc_seq_pkg::STAT_POS_LSB +: adc_seq_pkg::CNT_W] =
                pos_reg;
            rdata_next[adc_seq_pkg::STAT_MODE_LSB +: adc_seq_pkg::MODE_W] =
                mode;
            rdata_next[adc_seq_pkg::STAT_PHASE_BIT] = phase_reg;
        end else if (sel_cfg) begin
            rdata_next[adc_seq_pkg::OSR_W-1:0] = cfg_reg[cfg_idx];
        end else if (sel_slot) begin
            rdata_next[adc_seq_pkg::IN_W-1:0] = slot_reg[slot_idx];
        end
    end

    // register writes; writes to unmapped addresses are dropped
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_std_reg  <= adc_seq_pkg::CTRL_SEL_RST;
            slot_cnt_reg <= adc_seq_pkg::CNT_RST;
            mask_reg     <= adc_seq_pkg::MASK_RST;
            temp_en_reg  <= adc_seq_pkg::TEMP_RST;
            for (int i = 0; i < adc_seq_pkg::N_INPUTS; i++) begin
                cfg_reg[i] <= adc_seq_pkg::OSR_RST;
            end
            for (int i = 0; i < NUM_SLOTS; i++) begin
                slot_reg[i] <= adc_seq_pkg::SLOT_RST;
            end
        end else if (wr_go) begin
            if (sel_ctrl) begin
                sel_std_reg  <= avs_writedata[adc_seq_pkg::CTRL_SEL_BIT];
                slot_cnt_reg <= avs_writedata[adc_seq_pkg::CNT_W-1:0];
            end
            if (sel_mask) begin
                mask_reg <= avs_writedata[7:0];
            end
            if (sel_temp) begin
                temp_en_reg <= avs_writedata[0];
            end
            if (sel_cfg) begin
                cfg_reg[cfg_idx] <= avs_writedata[adc_seq_pkg::OSR_W-1:0];
            end
            // slot holds three bits: no code reaches the sensor
            if (sel_slot) begin
                slot_reg[slot_idx] <= avs_writedata[adc_seq_pkg::IN_W-1:0];
            end
        end
    end

    // position walk of the active sequence
    always_comb begin
        pos_next   = pos_reg;
        phase_next = phase_reg;
        wrap_next  = 1'b0;
        if (restart_reg) begin
            pos_next   = is_std ? std_first : 4'h0;
            phase_next = 1'b0;
        end else if (step) begin
            case (mode)
                adc_seq_pkg::MODE_STD: begin
                    pos_next  = std_nxt;
                    wrap_next = std_nxt <= pos_reg;
                end
                adc_seq_pkg::MODE_ADV: begin
                    if (phase_reg) begin
                        pos_next   = 4'h0;
                        phase_next = 1'b0;
                        wrap_next  = 1'b1;
                    end else if (adv_last && temp_en_reg) begin
                        phase_next = 1'b1;
                    end else if (adv_last) begin
                        pos_next  = 4'h0;
                        wrap_next = 1'b1;
                    end else begin
                        pos_next = pos_reg + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // mux follows the walk; command mode takes the host's pick
    always_comb begin
        mux_next = mux_reg;
        if (is_std) begin
            mux_next = pos_next;
        end else if (is_adv && (step || restart_reg)) begin
            // slot writes never move a live mux
            mux_next = phase_next ? adc_seq_pkg::CH_TEMP
                                  : {1'b0, slot_reg[pos_next]};
        end else if (step && cmd_pend_reg) begin
            mux_next = cmd_chan_reg;
        end
    end

    // per-channel config in other modes, config 0 in standard and for the sensor
    wire [2:0] cfg_sel_next =
        (is_std || mux_next == adc_seq_pkg::CH_TEMP) ? 3'h0
                                                     : mux_next[2:0];

    // the mux only moves at a conversion end or a restart
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pos_reg     <= 4'h0;
            phase_reg   <= 1'b0;
            mux_reg     <= 4'h0;
            cfg_sel_reg <= 3'h0;
            osr_cnt_reg <= '0;
            result_reg  <= 1'b0;
            wrap_reg    <= 1'b0;
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= restart;
            pos_reg     <= pos_next;
            phase_reg   <= phase_next;
            mux_reg     <= mux_next;
            cfg_sel_reg <= cfg_sel_next;
            // a conversion in the restart cycle counts nothing
            result_reg  <= step & ~restart_reg;
            wrap_reg    <= wrap_next;
            if (step || restart_reg) begin
                osr_cnt_reg <= '0;
            end else if (conversion_done) begin
                osr_cnt_reg <= osr_cnt_reg
                               + adc_seq_pkg::OSR_CNT_W'(1);
            end
        end
    end

    // host pick: a new pick in the consuming cycle wins
    wire pick_ok = next_channel_valid
                   && (next_channel <= adc_seq_pkg::CH_TEMP);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_chan_reg <= 4'h0;
            cmd_pend_reg <= 1'b0;
        end else if (pick_ok) begin
            cmd_chan_reg <= next_channel;
            cmd_pend_reg <= 1'b1;
        end else if (is_cmd && step) begin
            cmd_pend_reg <= 1'b0;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign mux_select      = mux_reg;
    assign config_select   = cfg_sel_reg;
    assign result_done     = result_reg;
    assign seq_wrap        = wrap_reg;

    // checks
    sequence s_reset_rel;
        !$past(reset_n) ##0 reset_n;
    endsequence

    a_std_after_reset: assert property (
        @(posedge core_clk) s_reset_rel |-> is_std
    ) else $error("standard sequencer not selected after reset");

    a_mux_only_on_end: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !step && !restart_reg
        |=> $stable(mux_select)
    ) else $error("mux moved without a conversion end");

    a_std_osr_hold: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_std && conversion_done && !step && !restart_reg && !restart
        |=> $stable(mux_select) && !result_done
    ) else $error("channel left before its oversampling count");

    a_std_enabled_ch: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_std && step && !restart_reg && !restart && (mask9 != 9'h0)
        |=> mask9[mux_select] && result_done
    ) else $error("standard mode converted a disabled channel");

    a_slot_bound: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_adv && !restart_reg && $past(is_adv) |-> pos_reg <= slot_eff
    ) else $error("slot position beyond active count");

    a_adv_no_temp_slot: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_adv && !phase_reg && !restart_reg
        |-> mux_select != adc_seq_pkg::CH_TEMP
    ) else $error("sensor converted from a slot");

    a_temp_after_last: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_adv && step && adv_last && temp_en_reg && !phase_reg
        && !restart_reg && !restart
        |=> mux_select == adc_seq_pkg::CH_TEMP && !seq_wrap
    ) else $error("sensor not converted after last slot");

    a_adv_wrap_zero: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_adv && step && phase_reg && !restart_reg && !restart
        |=> pos_reg == 4'h0 && !phase_reg && seq_wrap
    ) else $error("sequence did not restart at slot zero");

    a_std_wrap_flag: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_std && step && !restart_reg && (std_nxt <= pos_reg)
        |=> seq_wrap ##1 !seq_wrap || $past(step)
    ) else $error("standard wrap not flagged");

    a_shared_config: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_std && !restart |=> config_select == 3'h0
    ) else $error("standard mode used a per-channel config");

    a_cmd_pick_load: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        is_cmd && step && cmd_pend_reg && !restart_reg && !restart
        |=> mux_select == $past(cmd_chan_reg) && result_done
    ) else $error("host channel pick not applied");

endmodule

// *** verification/conv_core_model.sv ***
// converter core stand-in: paced end-of-conversion strobes
module conv_core_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // pacing from the bench
    input  wire logic       run,
    input  wire logic [3:0] gap,
    // strobe to the sequencer
    output logic            conversion_done
);
    logic [3:0] wait_reg;

    // one conversion per strobe period; silent while not running
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg        <= 4'h0;
            conversion_done <= 1'b0;
        end else if (run && wait_reg >= gap) begin
            wait_reg        <= 4'h0;
            conversion_done <= 1'b1;
        end else begin
            conversion_done <= 1'b0;
            wait_reg        <= run ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule

// *** verification/adc_channel_sequencer_tb.sv ***
// self-checking bench for the adc channel sequencer
module adc_channel_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk;
    logic        reset_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        conversion_done;
    logic [3:0]  mux_select;
    logic [2:0]  config_select;
    logic        result_done;
    logic        seq_wrap;
    logic [3:0]  next_channel;
    logic        next_channel_valid;
    logic        run;
    logic [3:0]  gap;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          carry;
    logic [31:0] rd;
    logic [1:0]  cfg [0:8];
    logic [3:0]  seq [$];

    adc_channel_sequencer dut_u (
        .core_clk(core_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .conversion_done(conversion_done), .mux_select(mux_select),
        .config_select(config_select), .result_done(result_done),
        .seq_wrap(seq_wrap), .next_channel(next_channel),
        .next_channel_valid(next_channel_valid)
    );

    conv_core_model core_u (
        .core_clk(core_clk), .reset_n(reset_n), .run(run), .gap(gap),
        .conversion_done(conversion_done)
    );

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    // longest std pass is 9 entries x 64 x 4 cycles, twice
    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 60000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // one avalon cycle; starts on an edge so strobes never double-drive
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int k;
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= !wr;
        avs_write      <= wr;
        k = 0;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && k < 100) begin
            k++;
            @(posedge core_clk);
        end
        if (k >= 100)
            error_cnt++;
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    function automatic int ratio(input logic [1:0] f);
        return 1 << (2 * f);
    endfunction

    // waits for one result; ew < 0 skips the wrap check, er 0 the count
    task automatic wait_result(input logic [3:0] p, input logic pv,
                               input logic [3:0] em, input logic [2:0] ec,
                               input int ew, input int er);
        int n;
        int k;
        next_channel       <= p;
        next_channel_valid <= pv;
        n = carry;
        k = 0;
        @(posedge core_clk);
        next_channel_valid <= 1'b0;
        while (result_done !== 1'b1 && k < 2000) begin
            n += int'(conversion_done);
            k++;
            @(posedge core_clk);
        end
        carry = int'(conversion_done);
        check({31'h0, result_done}, 32'h1);
        check({28'h0, mux_select}, {28'h0, em});
        check({29'h0, config_select}, {29'h0, ec});
        if (ew >= 0)
            check({31'h0, seq_wrap}, 32'(ew));
        if (er > 0)
            check(32'(n), 32'(er));
    endtask

    task automatic settle(input logic [2:0] mode, input logic chk0);
        bus(0, 8'h0c, 32'h0, 4'hf);
        check({29'h0, rd[10:8]}, {29'h0, mode});
        check({31'h0, rd[11]}, 32'h0);
        if (chk0)
            check({28'h0, rd[3:0]}, {28'h0, seq[0]});
        repeat (3) @(posedge core_clk);
        if (chk0)
            check({28'h0, mux_select}, {28'h0, seq[0]});
        run <= 1'b1;
    endtask

    task automatic run_std(input logic [7:0] m, input logic t,
                           input logic [1:0] f, input logic [3:0] g);
        int sz;
        run <= 1'b0;
        gap <= g;
        carry = 0;
        bus(1, 8'h20, {30'h0, f}, 4'hf);
        bus(1, 8'h24, {30'h0, f + 2'h1}, 4'hf);
        bus(1, 8'h04, {24'h0, m}, 4'hf);
        bus(1, 8'h08, {31'h0, t}, 4'hf);
        bus(1, 8'h00, 32'h80, 4'hf);
        seq.delete();
        for (int i = 0; i < 8; i++)
            if (m[i]) seq.push_back(4'(i));
        if (t) seq.push_back(4'h8);
        sz = seq.size();
        settle(3'b001, 1'b1);
        for (int i = 1; i <= 2 * sz; i++)
            wait_result(4'h0, 1'b0, seq[i % sz], 3'h0, int'(i % sz == 0),
                        ratio(f));
    endtask

    task automatic run_adv(input logic [3:0] n, input logic t);
        logic [3:0] v;
        logic [3:0] c;
        int         sz;
        run <= 1'b0;
        gap <= 4'($urandom_range(1, 3));
        carry = 0;
        for (int i = 0; i < 8; i++) begin
            cfg[i] = 2'($urandom_range(0, 1));
            bus(1, 8'(8'h20 + 4 * i), {30'h0, cfg[i]}, 4'hf);
        end
        seq.delete();
        for (int s = 0; s < 16; s++) begin
            v = 4'($urandom_range(0, 8));
            bus(1, 8'(8'h40 + 4 * s), {28'h0, v}, 4'hf);
            // a sensor code in a slot lands as input 0
            if (s <= n) seq.push_back({1'b0, v[2:0]});
        end
        if (t) seq.push_back(4'h8);
        bus(1, 8'h08, {31'h0, t}, 4'hf);
        bus(1, 8'h00, {28'h0, n}, 4'hf);
        sz = seq.size();
        settle(3'b010, 1'b1);
        for (int i = 1; i <= 2 * sz; i++) begin
            c = seq[i % sz];
            wait_result(4'h0, 1'b0, c, (c == 4'h8) ? 3'h0 : c[2:0],
                        int'(i % sz == 0),
                        ratio(cfg[seq[(i - 1) % sz]]));
        end
    endtask

    task automatic run_cmd();
        logic [3:0] p;
        logic [3:0] nx;
        logic [3:0] cur;
        run <= 1'b0;
        gap <= 4'($urandom_range(2, 3));
        carry = 0;
        for (int i = 0; i < 8; i++) begin
            cfg[i] = 2'($urandom_range(0, 1));
            bus(1, 8'(8'h20 + 4 * i), {30'h0, cfg[i]}, 4'hf);
        end
        bus(1, 8'h00, 32'h0, 4'hf);
        settle(3'b100, 1'b0);
        cur = 4'hf;
        // picks beyond 8 are ignored and leave the mux alone
        for (int i = 0; i < 14; i++) begin
            p = 4'((i == 0) ? $urandom_range(0, 8) : $urandom_range(0, 11));
            nx = (p < 4'h9) ? p : cur;
            wait_result(p, 1'b1, nx, (nx == 4'h8) ? 3'h0 : nx[2:0], -1,
                        (cur == 4'hf) ? 0 : ratio(cfg[cur]));
            cur = nx;
        end
    endtask

    initial begin
        reset_n            = 1'b0;
        avs_address        = 8'h00;
        avs_read           = 1'b0;
        avs_write          = 1'b0;
        avs_writedata      = 32'h0;
        avs_byteenable     = 4'h0;
        next_channel       = 4'h0;
        next_channel_valid = 1'b0;
        run                = 1'b0;
        gap                = 4'h1;
        cfg[8]             = 2'h0;
        void'($urandom(98));
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        bus(0, 8'h00, 32'h0, 4'hf);
        check(rd, 32'h80);
        bus(0, 8'h04, 32'h0, 4'hf);
        check(rd, 32'h01);
        bus(0, 8'h0c, 32'h0, 4'hf);
        check({29'h0, rd[10:8]}, 32'h1);
        bus(0, 8'h10, 32'h0, 4'hf);
        check(rd, 32'h0);
        bus(0, 8'h05, 32'h0, 4'hf);
        check(rd, 32'h0);
        bus(1, 8'h04, 32'hff, 4'h0);
        bus(0, 8'h04, 32'h0, 4'hf);
        check(rd, 32'h01);
        bus(1, 8'h00, 32'hffffffff, 4'hf);
        bus(0, 8'h00, 32'h0, 4'hf);
        check(rd, 32'h8f);
        run_std(8'h01, 1'b0, 2'h1, 4'h1);
        run_std(8'hff, 1'b1, 2'h0, 4'h0);
        run_std(8'($urandom_range(1, 255)), 1'($urandom_range(0, 1)),
                2'($urandom_range(0, 3)), 4'($urandom_range(0, 3)));
        run_adv(4'ha, 1'b1);
        run_adv(4'hf, 1'b0);
        // a zero slot count selects command mode, so one is the minimum
        run_adv(4'h1, 1'b0);
        run_adv(4'($urandom_range(1, 15)), 1'($urandom_range(0, 1)));
        run_cmd();
        wrap_up();
    end
endmodule
